// file: core/sfh_pkg.sv
// Constants and types shared by the serial flash command front end.
package sfh_pkg;

  // ==========================================================
  // Instruction codes
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_SECT_ERASE_A = 8'h20;
  localparam logic [7:0] OP_SECT_ERASE_B = 8'hD7;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_WRITE_ALLOW = 8'h06;
  localparam logic [7:0] OP_WRITE_FORBID = 8'h04;
  localparam logic [7:0] OP_ID_READ = 8'hAB;

  // ==========================================================
  // Status register field positions
  localparam int BUSY_BIT = 0;
  localparam int WLATCH_BIT = 1;
  localparam int LEVEL0_BIT = 2;
  localparam int LEVEL2_BIT = 4;
  localparam int BSEL_BIT = 5;
  localparam int LOCK_BIT = 7;

  // ==========================================================
  // Framing counts and array geometry
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [1:0] LAST_ADDR_BYTE = 2'h2;
  localparam logic [2:0] NB_OPCODE_ONLY = 3'h1;
  localparam logic [2:0] NB_STATUS_WRITE = 3'h2;
  localparam logic [2:0] NB_ADDR_ONLY = 3'h4;
  localparam logic [2:0] NB_PROG_MIN = 3'h5;
  localparam logic [2:0] NB_SAT = 3'h7;
  localparam logic [19:0] ARRAY_BYTES = 20'h80000;
  localparam logic [19:0] EIGHTH_BYTES = 20'h10000;

  // ==========================================================
  // Reset values
  localparam logic [3:0] SYNC_INIT = 4'h7;
  localparam logic [7:0] STAT_SYNC_INIT = 8'h00;

  // Shift phase of the serial front end, one-hot.
  typedef enum logic [3:0] {
    PH_OPC = 4'b0001,
    PH_ADR = 4'b0010,
    PH_OUT = 4'b0100,
    PH_IN = 4'b1000
  } sfh_phase_t;

  // Kind of array write handed to the array controller.
  typedef enum logic [1:0] {
    WK_PAGE = 2'h0,
    WK_SECT = 2'h1,
    WK_BLOCK = 2'h2,
    WK_CHIP = 2'h3
  } sfh_wkind_t;

endpackage

// file: core/sfh_front.sv
// Serial flash command front end: pause, status register, protection, framing.
//
// Functional notes
// - Pause starts on pause-input fall, clock low
// - Pause ends on rise; sequence kept
// - Paused: output floats, input and clock ignored
// - Deselect during pause returns to standby
// - Status write refused if pin low, lock set
// - Bit 0 shows busy, read-only, zero at start
// - Bit 1 shows write latch; gates writes
// - Latch cleared at start and write completions; cleared here when the write is accepted, before busy ends
// - Level 1..3, top select: top region protected
// - Level 1..3, bottom select: bottom region protected
// - Level bit 2 all protected; zero none
// - Writes into protected region are ignored
// - Chip erase only with no protection bits
// - Protection and lock bits nonvolatile; bit 6 zero
// - Chip select fall starts; bytes MSB first
// - Early deselect mid byte abandons instruction
// - Read 03h, three address bytes, streams
// - Identifier after 24 dummy bits, streams
// - Sample on rising, drive after falling edge
`timescale 1ns/10ps

module sfh_front #(
  parameter int ADDR_W = 19,
  parameter int BUSY_CYCLES = 200,
  // Identifier value is arbitrary.
  parameter logic [7:0] DEV_ID = 8'h5A,
  parameter logic [7:0] NV_INIT = 8'h00
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_si,
  input wire logic i_hold_n,
  input wire logic i_wp_n,
  input wire logic [7:0] i_rd_data,
  output logic o_so,
  output logic o_so_oe_n,
  output logic [ADDR_W-1:0] o_rd_addr,
  output logic o_wr_req,
  output sfh_pkg::sfh_wkind_t o_wr_kind,
  output logic [ADDR_W-1:0] o_wr_addr,
  output logic [7:0] o_wr_data,
  output logic [7:0] o_status
);

  // ==========================================================
  // Link side, clocked by the serial clock
  logic [2:0] bit_q;
  sfh_pkg::sfh_phase_t ph_q;
  logic [7:0] op_q;
  logic [7:0] sh_q;
  logic [7:0] sh_d;
  logic [15:0] adr_q;
  logic [1:0] abyte_q;
  logic frm_q;
  logic [7:0] tx_q;
  logic so_q;
  logic [7:0] src;
  logic byte_end;

  assign sh_d = {sh_q[6:0], i_si};
  assign byte_end = (bit_q == sfh_pkg::LAST_BIT);

  // Deselect clears the frame at once, so a partial byte is simply lost.
  always_ff @(posedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      bit_q <= 3'h0;
      ph_q <= sfh_pkg::PH_OPC;
      op_q <= 8'h00;
      sh_q <= 8'h00;
      adr_q <= 16'h0000;
      abyte_q <= 2'h0;
      frm_q <= 1'b0;
    end else if (i_hold_n) begin
      frm_q <= 1'b1;
      sh_q <= sh_d;
      bit_q <= bit_q + 3'h1;
      if (byte_end) begin
        case (ph_q)
          sfh_pkg::PH_OPC: begin
            op_q <= sh_d;
            if (sh_d == sfh_pkg::OP_STATUS_READ) begin
              ph_q <= sfh_pkg::PH_OUT;
            end else if (sh_d == sfh_pkg::OP_READ || sh_d == sfh_pkg::OP_ID_READ ||
                         sh_d == sfh_pkg::OP_PAGE_PROG || sh_d == sfh_pkg::OP_BLOCK_ERASE ||
                         sh_d == sfh_pkg::OP_SECT_ERASE_A ||
                         sh_d == sfh_pkg::OP_SECT_ERASE_B) begin
              ph_q <= sfh_pkg::PH_ADR;
            end else begin
              ph_q <= sfh_pkg::PH_IN;
            end
          end
          sfh_pkg::PH_ADR: begin
            adr_q <= {adr_q[7:0], sh_d};
            abyte_q <= abyte_q + 2'h1;
            if (abyte_q == sfh_pkg::LAST_ADDR_BYTE) begin
              if (op_q == sfh_pkg::OP_READ || op_q == sfh_pkg::OP_ID_READ) begin
                ph_q <= sfh_pkg::PH_OUT;
              end else begin
                ph_q <= sfh_pkg::PH_IN;
              end
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Record of the frame, kept after deselect for the system side
  logic tog_q;
  logic [7:0] rec_op_q;
  logic [23:0] rec_adr_q;
  logic [7:0] rec_dat_q;
  logic rec_dok_q;
  logic [2:0] rec_nb_q;
  logic rec_frag_q;
  logic [ADDR_W-1:0] rd_addr_q;

  always_ff @(posedge i_sck or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tog_q <= 1'b0;
      rec_op_q <= 8'h00;
      rec_adr_q <= 24'h000000;
      rec_dat_q <= 8'h00;
      rec_dok_q <= 1'b0;
      rec_nb_q <= 3'h0;
      rec_frag_q <= 1'b0;
      rd_addr_q <= '0;
    end else if (!i_cs_n && i_hold_n) begin
      if (!frm_q) begin
        tog_q <= ~tog_q;
        rec_nb_q <= 3'h0;
        rec_dok_q <= 1'b0;
      end else if (byte_end && rec_nb_q != sfh_pkg::NB_SAT) begin
        rec_nb_q <= rec_nb_q + 3'h1;
      end
      rec_frag_q <= !byte_end;
      if (byte_end && ph_q == sfh_pkg::PH_OPC) begin
        rec_op_q <= sh_d;
      end
      if (byte_end && ph_q == sfh_pkg::PH_ADR) begin
        rec_adr_q <= {adr_q, sh_d};
        if (abyte_q == sfh_pkg::LAST_ADDR_BYTE) begin
          rd_addr_q <= ADDR_W'({adr_q, sh_d});
        end
      end
      // The pointer wraps to zero past the top of the array.
      if (byte_end && ph_q == sfh_pkg::PH_OUT) begin
        rd_addr_q <= rd_addr_q + ADDR_W'(1);
      end
      if (byte_end && ph_q == sfh_pkg::PH_IN && (!rec_dok_q || !frm_q)) begin
        rec_dat_q <= sh_d;
        rec_dok_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Status word brought into the link domain
  logic [7:0] stat_s1_q;
  logic [7:0] stat_s2_q;
  logic [7:0] status;

  always_ff @(posedge i_sck or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      stat_s1_q <= sfh_pkg::STAT_SYNC_INIT;
      stat_s2_q <= sfh_pkg::STAT_SYNC_INIT;
    end else begin
      stat_s1_q <= status;
      stat_s2_q <= stat_s1_q;
    end
  end

  always_comb begin
    if (op_q == sfh_pkg::OP_STATUS_READ) begin
      src = stat_s2_q;
    end else if (op_q == sfh_pkg::OP_ID_READ) begin
      src = DEV_ID;
    end else begin
      src = i_rd_data;
    end
  end

  // Output bits change on the falling edge so the host samples a settled level.
  always_ff @(negedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      tx_q <= 8'h00;
      so_q <= 1'b0;
    end else if (i_hold_n && ph_q == sfh_pkg::PH_OUT) begin
      if (bit_q == 3'h0) begin
        so_q <= src[7];
        tx_q <= {src[6:0], 1'b0};
      end else begin
        so_q <= tx_q[7];
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end

  assign o_so = so_q;
  assign o_rd_addr = rd_addr_q;

  // ==========================================================
  // Pin synchronisers on the system clock
  logic [3:0] pin_in;
  logic [3:0] pin_st;

  assign pin_in = {tog_q, i_wp_n, i_hold_n, i_cs_n};

  for (genvar g = 0; g < 4; g++) begin : g_sync
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic st_q;
    always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
        s1_q <= sfh_pkg::SYNC_INIT[g];
        s2_q <= sfh_pkg::SYNC_INIT[g];
        s3_q <= sfh_pkg::SYNC_INIT[g];
        st_q <= sfh_pkg::SYNC_INIT[g];
      end else begin
        s1_q <= pin_in[g];
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q) begin
          st_q <= s3_q;
        end
      end
    end
    assign pin_st[g] = st_q;
  end

  // ==========================================================
  // Execution at deselect
  logic cs_prev_q;
  logic seen_q;
  logic wl_q;
  logic [2:0] lvl_q;
  logic bsel_q;
  logic lock_q;
  logic busy_q;
  logic [$clog2(BUSY_CYCLES+1)-1:0] bcnt_q;
  logic exec;
  logic go;
  logic prot;
  logic do_pp;
  logic do_se;
  logic do_be;
  logic do_ce;
  logic do_sr;
  logic do_wen;
  logic do_wdi;
  logic wr_start;

  function automatic logic in_prot(input logic [18:0] a, input logic [2:0] lv, input logic tb);
    logic [19:0] sz;
    sz = sfh_pkg::EIGHTH_BYTES << (lv[1:0] - 2'h1);
    in_prot = 1'b0;
    if (lv[2]) begin
      in_prot = 1'b1;
    end else if (lv[1:0] != 2'h0) begin
      if (tb) begin
        in_prot = ({1'b0, a} < sz);
      end else begin
        in_prot = ({1'b0, a} >= (sfh_pkg::ARRAY_BYTES - sz));
      end
    end
  endfunction

  // Record fields are stable here: no serial edge arrives while deselected.
  assign exec = pin_st[0] && !cs_prev_q && (pin_st[3] != seen_q) && !rec_frag_q;
  assign go = exec && !busy_q;
  assign prot = in_prot(rec_adr_q[18:0], lvl_q, bsel_q);
  assign do_pp = go && wl_q && rec_op_q == sfh_pkg::OP_PAGE_PROG &&
                 rec_nb_q >= sfh_pkg::NB_PROG_MIN && !prot;
  assign do_se = go && wl_q && (rec_op_q == sfh_pkg::OP_SECT_ERASE_A ||
                 rec_op_q == sfh_pkg::OP_SECT_ERASE_B) &&
                 rec_nb_q == sfh_pkg::NB_ADDR_ONLY && !prot;
  assign do_be = go && wl_q && rec_op_q == sfh_pkg::OP_BLOCK_ERASE &&
                 rec_nb_q == sfh_pkg::NB_ADDR_ONLY && !prot;
  assign do_ce = go && wl_q && (rec_op_q == sfh_pkg::OP_CHIP_ERASE_A ||
                 rec_op_q == sfh_pkg::OP_CHIP_ERASE_B) &&
                 rec_nb_q == sfh_pkg::NB_OPCODE_ONLY &&
                 lvl_q == 3'h0 && !bsel_q;
  assign do_sr = go && wl_q && rec_op_q == sfh_pkg::OP_STATUS_WRITE &&
                 rec_nb_q == sfh_pkg::NB_STATUS_WRITE && !(!pin_st[2] && lock_q);
  assign do_wen = go && rec_op_q == sfh_pkg::OP_WRITE_ALLOW &&
                  rec_nb_q == sfh_pkg::NB_OPCODE_ONLY;
  assign do_wdi = go && rec_op_q == sfh_pkg::OP_WRITE_FORBID &&
                  rec_nb_q == sfh_pkg::NB_OPCODE_ONLY;
  assign wr_start = do_pp || do_se || do_be || do_ce;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cs_prev_q <= 1'b1;
      seen_q <= 1'b0;
    end else begin
      cs_prev_q <= pin_st[0];
      if (pin_st[0] && !cs_prev_q) begin
        seen_q <= pin_st[3];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wl_q <= 1'b0;
    end else if (do_wen) begin
      wl_q <= 1'b1;
    end else if (do_wdi || wr_start || do_sr) begin
      wl_q <= 1'b0;
    end
  end

  // Reset reloads the stored image; only an accepted status write alters it.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      lvl_q <= NV_INIT[sfh_pkg::LEVEL2_BIT:sfh_pkg::LEVEL0_BIT];
      bsel_q <= NV_INIT[sfh_pkg::BSEL_BIT];
      lock_q <= NV_INIT[sfh_pkg::LOCK_BIT];
    end else if (do_sr) begin
      lvl_q <= rec_dat_q[sfh_pkg::LEVEL2_BIT:sfh_pkg::LEVEL0_BIT];
      bsel_q <= rec_dat_q[sfh_pkg::BSEL_BIT];
      lock_q <= rec_dat_q[sfh_pkg::LOCK_BIT];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      busy_q <= 1'b0;
      bcnt_q <= '0;
    end else if (wr_start) begin
      busy_q <= 1'b1;
      bcnt_q <= ($clog2(BUSY_CYCLES+1))'(BUSY_CYCLES - 1);
    end else if (busy_q) begin
      if (bcnt_q == '0) begin
        busy_q <= 1'b0;
      end else begin
        bcnt_q <= bcnt_q - 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_wr_req <= 1'b0;
      o_wr_kind <= sfh_pkg::WK_PAGE;
      o_wr_addr <= '0;
      o_wr_data <= 8'h00;
    end else begin
      o_wr_req <= wr_start;
      if (wr_start) begin
        o_wr_addr <= ADDR_W'(rec_adr_q);
        o_wr_data <= rec_dat_q;
        if (do_pp) begin
          o_wr_kind <= sfh_pkg::WK_PAGE;
        end else if (do_se) begin
          o_wr_kind <= sfh_pkg::WK_SECT;
        end else if (do_be) begin
          o_wr_kind <= sfh_pkg::WK_BLOCK;
        end else begin
          o_wr_kind <= sfh_pkg::WK_CHIP;
        end
      end
    end
  end

  // Output drive follows the synchronised pins, so it lags them by a few system clocks.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_so_oe_n <= 1'b1;
    end else begin
      o_so_oe_n <= !(!pin_st[0] && pin_st[1]);
    end
  end

  assign status = {lock_q, 1'b0, bsel_q, lvl_q, wl_q, busy_q};
  assign o_status = status;

endmodule

// file: sim/sfh_front_assertions.sv
// Concurrent checks on the ports of the serial flash front end.
`timescale 1ns/10ps
module sfh_front_chk (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_cs_n,
  input wire logic i_hold_n,
  input wire logic o_so_oe_n,
  input wire logic o_wr_req,
  input wire sfh_pkg::sfh_wkind_t o_wr_kind,
  input wire logic [7:0] o_status
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // ==========================================================
  // Assertions
  reset_clear_a: assert property (disable iff (1'b0) i_sys_rst |=> o_so_oe_n && !o_wr_req
    && o_status[1:0] == 2'h0) else $error("reset state wrong");
  spare_zero_a: assert property (o_status[6] == 1'b0) else $error("bit 6 set");
  req_pulse_a: assert property (o_wr_req |=> !o_wr_req) else $error("long write pulse");
  latch_gate_a: assert property (o_wr_req |-> $past(o_status[1])) else $error("no latch");
  latch_clear_a: assert property (o_wr_req |-> ##[0:2] !o_status[1])
    else $error("latch kept");
  busy_set_a: assert property (o_wr_req |-> ##[0:2] o_status[0]) else $error("no busy");
  full_prot_a: assert property (o_wr_req |-> !$past(o_status[4]))
    else $error("write in full protection");
  chip_gate_a: assert property (o_wr_req && o_wr_kind == sfh_pkg::WK_CHIP
    |-> $past(o_status[5:2]) == 4'h0) else $error("chip erase while protected");
  hold_float_a: assert property (!i_hold_n [*6] |-> o_so_oe_n) else $error("driven in pause");
  idle_float_a: assert property (i_cs_n [*6] |-> o_so_oe_n) else $error("driven deselected");
  frame_stable_a: assert property (!i_cs_n [*6] |-> $stable(o_status[7:2]))
    else $error("protection moved in frame");
  cover property (o_wr_req && o_wr_kind == sfh_pkg::WK_CHIP);
  cover property (o_wr_req && o_wr_kind == sfh_pkg::WK_PAGE);
  cover property (!i_hold_n [*6]);
endmodule

bind sfh_front sfh_front_chk sfh_front_chk_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_cs_n(i_cs_n), .i_hold_n(i_hold_n), .o_so_oe_n(o_so_oe_n), .o_wr_req(o_wr_req),
  .o_wr_kind(o_wr_kind), .o_status(o_status));

// file: sim/sfh_host.sv
// Mode 0 serial host that frames instructions towards the flash front end.
`timescale 1ns/10ps
module sfh_host (
  input wire logic i_so,
  output logic o_sck,
  output logic o_cs_n,
  output logic o_si,
  output logic o_hold_n
);
  // The clock only moves inside frames, 30 ns period.
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b0;
    o_si = 1'b0;
    o_hold_n = 1'b1;
    // A deselect edge clears the frame logic, which has no other reset.
    #2 o_cs_n = 1'b1;
  end
  task automatic bit_io(input logic b, output logic r);
    o_si = b;
    #15 o_sck = 1'b1;
    r = i_so;
    #15 o_sck = 1'b0;
  endtask
  task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
  endtask
  // Start and stop add 348 ns around the bytes, so frame edges drift by 8 ns per frame against the 10 ns system clock grid.
  task automatic start();
    #3 o_cs_n = 1'b0;
    #30;
  endtask
  // The long gap lets the flash execute before the next frame starts.
  task automatic stop();
    #15 o_cs_n = 1'b1;
    #300;
  endtask
  task automatic hold_on();
    #5 o_hold_n = 1'b0;
    #60;
  endtask
  task automatic hold_off();
    #5 o_hold_n = 1'b1;
    #60;
  endtask
endmodule

// file: sim/tb_top.sv
// Self-checking bench for the serial flash front end.
`timescale 1ns/10ps
module tb_top;
  localparam logic [7:0] ID = 8'h5A; // Arbitrary identifier value.
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b0;
  logic i_wp_n = 1'b1;
  logic last_so = 1'b0;
  wire i_sck, i_cs_n, i_si, i_hold_n, o_so, o_so_oe_n, o_wr_req;
  wire [18:0] o_rd_addr, o_wr_addr;
  wire [7:0] i_rd_data, o_wr_data, o_status;
  sfh_pkg::sfh_wkind_t o_wr_kind, kind_seen;
  logic [18:0] addr_seen;
  logic [7:0] data_seen, rx, v;
  logic b;
  int err_count = 0;
  int num_checks = 0;
  int wr_seen = 0;
  int n0;
  logic [7:0] st [9] = '{8'h04, 8'h04, 8'h24, 8'h24, 8'h10, 8'h2C, 8'h0C, 8'h08, 8'h28};
  logic [23:0] ad [9] = '{24'h070000, 24'h06FFFF, 24'h00FFFF, 24'h010000, 24'h040000,
    24'h040000, 24'h040000, 24'h05FFFF, 24'h01FFFF};
  logic ok [9] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  // A released output shows the inverse of its last level, never a lucky match.
  wire so_line = o_so_oe_n ? ~last_so : o_so;
  always #5 i_clk = ~i_clk;
  always @(posedge i_sck) if (o_so_oe_n === 1'b0) last_so <= o_so;
  assign i_rd_data = o_rd_addr[7:0] ^ 8'h3C;
  always @(posedge i_clk) begin
    if (o_wr_req === 1'b1) begin
      wr_seen <= wr_seen + 1;
      kind_seen <= o_wr_kind;
      addr_seen <= o_wr_addr;
      data_seen <= o_wr_data;
    end
  end
  sfh_front #(.BUSY_CYCLES(200), .DEV_ID(ID)) sfh_front_i (.i_clk(i_clk),
    .i_sys_rst(i_sys_rst), .i_sck(i_sck), .i_cs_n(i_cs_n), .i_si(i_si), .i_hold_n(i_hold_n),
    .i_wp_n(i_wp_n), .i_rd_data(i_rd_data), .o_so(o_so), .o_so_oe_n(o_so_oe_n),
    .o_rd_addr(o_rd_addr), .o_wr_req(o_wr_req), .o_wr_kind(o_wr_kind),
    .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data), .o_status(o_status));
  sfh_host sfh_host_i (.i_so(so_line), .o_sck(i_sck), .o_cs_n(i_cs_n), .o_si(i_si),
    .o_hold_n(i_hold_n));
  task automatic finish_test();
    if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic cmd1(input logic [7:0] op);
    sfh_host_i.start();
    sfh_host_i.byte_io(op, rx);
    sfh_host_i.stop();
  endtask
  task automatic wsr(input logic [7:0] s);
    cmd1(sfh_pkg::OP_WRITE_ALLOW);
    sfh_host_i.start();
    sfh_host_i.byte_io(sfh_pkg::OP_STATUS_WRITE, rx);
    sfh_host_i.byte_io(s, rx);
    sfh_host_i.stop();
  endtask
  task automatic chk_status(input logic [7:0] exp);
    sfh_host_i.start();
    sfh_host_i.byte_io(sfh_pkg::OP_STATUS_READ, rx);
    sfh_host_i.byte_io(8'h00, v);
    sfh_host_i.stop();
    check(v, exp);
  endtask
  task automatic addr_cmd(input logic [7:0] op, input logic [23:0] a);
    sfh_host_i.start();
    sfh_host_i.byte_io(op, rx);
    for (int i = 2; i >= 0; i--) sfh_host_i.byte_io(a[8*i+:8], rx);
  endtask
  task automatic send_bits(input logic [3:0] x);
    for (int i = 3; i >= 0; i--) sfh_host_i.bit_io(x[i], b);
  endtask
  task automatic wait_ready();
    int n = 0;
    while (o_status[0] !== 1'b0 && n < 400) begin
      @(posedge i_clk);
      n++;
    end
    check(n < 400, 1);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_latch();
    chk_status(8'h00);
    sfh_host_i.start();
    sfh_host_i.byte_io(sfh_pkg::OP_STATUS_WRITE, rx);
    sfh_host_i.byte_io(8'h9C, rx);
    sfh_host_i.stop();
    chk_status(8'h00);
    cmd1(sfh_pkg::OP_WRITE_ALLOW);
    chk_status(8'h02);
    cmd1(sfh_pkg::OP_WRITE_FORBID);
    chk_status(8'h00);
    wsr(8'h9C);
    chk_status(8'h9C);
  endtask
  task automatic t_lock();
    @(negedge i_clk) i_wp_n = 1'b0;
    wsr(8'h00);
    chk_status(8'h9E);
    cmd1(sfh_pkg::OP_WRITE_FORBID);
    @(negedge i_clk) i_wp_n = 1'b1;
    wsr(8'h00);
    chk_status(8'h00);
  endtask
  task automatic t_protect();
    for (int k = 0; k < 9; k++) begin
      wsr(st[k]);
      n0 = wr_seen;
      cmd1(sfh_pkg::OP_WRITE_ALLOW);
      addr_cmd(sfh_pkg::OP_SECT_ERASE_A, ad[k]);
      sfh_host_i.stop();
      check(wr_seen - n0, ok[k]);
      if (ok[k]) begin
        check(kind_seen, sfh_pkg::WK_SECT);
        check(addr_seen, ad[k][18:0]);
        wait_ready();
      end
      chk_status(ok[k] ? st[k] : (st[k] | 8'h02));
    end
    foreach (st[k]) if (k < 2) begin
      wsr(k == 0 ? 8'h04 : 8'h20);
      cmd1(sfh_pkg::OP_WRITE_ALLOW);
      n0 = wr_seen;
      cmd1(k == 0 ? sfh_pkg::OP_CHIP_ERASE_A : sfh_pkg::OP_CHIP_ERASE_B);
      check(wr_seen - n0, 0);
    end
    wsr(8'h00);
    cmd1(sfh_pkg::OP_WRITE_ALLOW);
    cmd1(sfh_pkg::OP_CHIP_ERASE_A);
    check(kind_seen, sfh_pkg::WK_CHIP);
    wait_ready();
  endtask
  task automatic t_busy();
    cmd1(sfh_pkg::OP_WRITE_ALLOW);
    addr_cmd(sfh_pkg::OP_PAGE_PROG, 24'h000123);
    sfh_host_i.byte_io(8'hA5, rx);
    sfh_host_i.stop();
    check({kind_seen, data_seen}, {sfh_pkg::WK_PAGE, 8'hA5});
    chk_status(8'h01);
    wait_ready();
    cmd1(sfh_pkg::OP_WRITE_ALLOW);
    addr_cmd(sfh_pkg::OP_BLOCK_ERASE, 24'h030000);
    sfh_host_i.stop();
    check({kind_seen, addr_seen}, {sfh_pkg::WK_BLOCK, 19'h30000});
    cmd1(sfh_pkg::OP_WRITE_ALLOW);
    wait_ready();
    chk_status(8'h00);
  endtask
  task automatic t_read_id();
    addr_cmd(sfh_pkg::OP_READ, 24'h000123);
    sfh_host_i.byte_io(8'h00, rx);
    check(rx, 8'h1F);
    sfh_host_i.byte_io(8'h00, rx);
    check(rx, 8'h18);
    sfh_host_i.stop();
    addr_cmd(sfh_pkg::OP_ID_READ, 24'h000000);
    sfh_host_i.byte_io(8'h00, rx);
    check(rx, ID);
    sfh_host_i.byte_io(8'h00, rx);
    check(rx, ID);
    sfh_host_i.stop();
  endtask
  task automatic t_pause();
    cmd1(sfh_pkg::OP_WRITE_ALLOW);
    sfh_host_i.start();
    sfh_host_i.byte_io(sfh_pkg::OP_STATUS_WRITE, rx);
    send_bits(4'hA);
    sfh_host_i.hold_on();
    check(o_so_oe_n, 1'b1);
    send_bits(4'hF);
    sfh_host_i.hold_off();
    send_bits(4'h8);
    sfh_host_i.stop();
    chk_status(8'hA8);
    cmd1(sfh_pkg::OP_WRITE_ALLOW);
    sfh_host_i.start();
    sfh_host_i.byte_io(sfh_pkg::OP_STATUS_WRITE, rx);
    sfh_host_i.byte_io(8'h00, rx);
    send_bits(4'h0);
    sfh_host_i.hold_on();
    sfh_host_i.stop();
    sfh_host_i.hold_off();
    chk_status(8'hAA);
    cmd1(sfh_pkg::OP_WRITE_FORBID);
    chk_status(8'hA8);
  endtask
  initial begin
    // A real rising edge is needed: the frame record and status flops on the serial clock reset on it asynchronously.
    #1 i_sys_rst = 1'b1;
    repeat (3) @(negedge i_clk);
    i_sys_rst = 1'b0;
    check(o_so_oe_n, 1'b1);
    repeat (5) @(negedge i_clk);
    t_latch();
    t_lock();
    t_protect();
    t_busy();
    t_read_id();
    t_pause();
    finish_test();
  end
  initial begin
    #500000;
    err_count++;
    finish_test();
  end
endmodule
